// File: inc/pfs_pkg.sv
// shared constants and carrier types for pin function selection
package pfs_pkg;
  // master/slave select field encodings
  localparam logic [1:0] PFS_MSC_STANDALONE = 2'h0;
  localparam logic [1:0] PFS_MSC_MASTER     = 2'h1;
  localparam logic [1:0] PFS_MSC_SLAVE      = 2'h2;
  localparam logic [1:0] PFS_MSC_RESERVED   = 2'h3;

  // field layout of the mode control register
  localparam int PFS_MODE_W      = 8;
  localparam int PFS_MSC_LSB     = 0;
  localparam int PFS_RFB_BIT     = 6;
  localparam logic [7:0] PFS_MODE_RST = 8'h00;

  // debug output control: bit 0 routes debug to port_a_pin0
  localparam int PFS_DBG_W       = 8;
  localparam int PFS_DBG_EN_BIT  = 0;
  localparam logic [7:0] PFS_DBG_RST = 8'h00;

  // pin lane: output, output enable, pull-up request
  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
  } pfs_pin_drv_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] dbg;
    logic       master_clear_input_en;
    logic       pu_a5;
    logic       ioc_a5;
  } pfs_cfg_t;
endpackage : pfs_pkg

// File: logic/pfs_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pfs_sync2
  import pfs_pkg::*;
(
  // clocking
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // data
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } pfs_sync_st_t;

  pfs_sync_st_t st_ff;
  pfs_sync_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule : pfs_sync2

// File: logic/pfs_top.sv
// pin function selection for shared general-purpose pins
//
// What this block does
// R1 - pin-change interrupt on master-clear pin is off while master clear enabled
// R2 - master-clear pin pull-up forced on when enabled, else software pull-up
// R3 - secondary reference out drives port_b_pin1 only in master mode
// R4 - switching sync in/out uses port_a_pin1 in master or slave mode
// R5 - bit 6 clear: feedback resistor and desat input; set: current-sense out
// R6 - debug output reaches port_a_pin0 only when debug control selects it
// R7 - pins with no special function stay under ordinary GPIO control
`timescale 1ns/10ps
module pfs_top
  import pfs_pkg::*;
(
  // clocking
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  // configuration
  input  wire logic [PFS_MODE_W-1:0] mode_control_reg,
  input  wire logic [PFS_DBG_W-1:0]  debug_output_control,
  input  wire logic                  master_clear_en,
  input  wire logic                  sw_pullup_a5,
  input  wire logic                  sw_ioc_en_a5,
  // gpio port controls for the three shared pins
  input  wire logic                  gpio_a0_o,
  input  wire logic                  gpio_a0_oe,
  input  wire logic                  gpio_a0_pu,
  input  wire logic                  gpio_a1_o,
  input  wire logic                  gpio_a1_oe,
  input  wire logic                  gpio_a1_pu,
  input  wire logic                  gpio_b1_o,
  input  wire logic                  gpio_b1_oe,
  input  wire logic                  gpio_b1_pu,
  // special function sources
  input  wire logic                  debug_out_src,
  input  wire logic                  sync_out_src,
  input  wire logic                  secondary_reference_out,
  // pins
  input  wire logic                  port_a_pin1_i,
  output logic                       port_a_pin0_o,
  output logic                       port_a_pin0_oe,
  output logic                       port_a_pin0_pu,
  output logic                       port_a_pin1_o,
  output logic                       port_a_pin1_oe,
  output logic                       port_a_pin1_pu,
  output logic                       port_b_pin1_o,
  output logic                       port_b_pin1_oe,
  output logic                       port_b_pin1_pu,
  output logic                       port_b_pin1_ana_sel,
  // master-clear pin controls
  output logic                       port_a_pin5_pu,
  output logic                       pin_change_interrupt_en_a5,
  // analog selects
  output logic                       feedback_resistor_en,
  output logic                       desat_positive_input_en,
  output logic                       current_sense_output_en,
  // sync input to the pwm logic
  output logic                       sync_in
);
  typedef struct packed {
    pfs_cfg_t     cfg;
    pfs_pin_drv_t a0;
    pfs_pin_drv_t a1;
    pfs_pin_drv_t b1;
    logic         b1_ana;
    logic         a5_pu;
    logic         a5_ioc;
    logic         fb_res;
    logic         desat;
    logic         current_sense_output;
  } pfs_state_t;

  pfs_state_t st_ff;
  pfs_state_t nxt_st;
  logic       sync_in_q;

  // config passes a register stage before it steers any pin, so a
  // mode change reaches the pins two edges after it is presented;
  // this keeps all pin controls free of decode glitches, but each value
  // written while software rewrites the mode field one bit at a time still reaches the pins
  // mode field decode, shared by pin routing and the sync gate
  function automatic logic [1:0] msc_of(input logic [PFS_MODE_W-1:0] m);
    msc_of = m[PFS_MSC_LSB +: 2];
  endfunction : msc_of

  function automatic pfs_pin_drv_t gpio_drv(input logic o, input logic oe, input logic pu);
    gpio_drv.o  = o;
    gpio_drv.oe = oe;
    gpio_drv.pu = pu;
  endfunction : gpio_drv

  // sync input arrives from a pin, so it is synchronised
  // two flops cost two cycles of latency on the slave sync path;
  // acceptable since the pwm logic only needs edge alignment, not phase
  pfs_sync2 i_pfs_sync2 (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .d       (port_a_pin1_i),
    .q       (sync_in_q)
  );

  always_comb begin
    logic [1:0] msc;
    logic       is_master;
    logic       is_slave;
    msc       = '0;
    is_master = 1'b0;
    is_slave  = 1'b0;
    nxt_st    = st_ff;
    if (clk_en) begin
      nxt_st.cfg.mode    = mode_control_reg;
      nxt_st.cfg.dbg     = debug_output_control;
      nxt_st.cfg.master_clear_input_en = master_clear_en;
      nxt_st.cfg.pu_a5   = sw_pullup_a5;
      nxt_st.cfg.ioc_a5  = sw_ioc_en_a5;
      msc       = msc_of(st_ff.cfg.mode);
      is_master = (msc == PFS_MSC_MASTER);
      is_slave  = (msc == PFS_MSC_SLAVE);
      // R1 ioc gated off
      nxt_st.a5_ioc = st_ff.cfg.ioc_a5 & ~st_ff.cfg.master_clear_input_en;
      // R2 forced pull-up
      nxt_st.a5_pu  = st_ff.cfg.master_clear_input_en | st_ff.cfg.pu_a5;
      // R6 debug routing
      if (st_ff.cfg.dbg[PFS_DBG_EN_BIT]) begin
        nxt_st.a0 = gpio_drv(debug_out_src, 1'b1, 1'b0);
      end else begin
        // R7 plain gpio
        nxt_st.a0 = gpio_drv(gpio_a0_o, gpio_a0_oe, gpio_a0_pu);
      end
      // R4 sync pin use: master drives, slave listens
      if (is_master) begin
        nxt_st.a1 = gpio_drv(sync_out_src, 1'b1, 1'b0);
      end else if (is_slave) begin
        nxt_st.a1 = gpio_drv(1'b0, 1'b0, 1'b0);
      end else begin
        // R7 plain gpio
        nxt_st.a1 = gpio_drv(gpio_a1_o, gpio_a1_oe, gpio_a1_pu);
      end
      // R3 reference only as master; analog path, digital driver released
      // reserved field code falls through to plain gpio on both pins
      nxt_st.b1_ana = is_master;
      if (is_master) begin
        nxt_st.b1 = gpio_drv(secondary_reference_out, 1'b0, 1'b0);
      end else begin
        // R7 plain gpio
        nxt_st.b1 = gpio_drv(gpio_b1_o, gpio_b1_oe, gpio_b1_pu);
      end
      // R5 feedback select
      nxt_st.fb_res = ~st_ff.cfg.mode[PFS_RFB_BIT];
      nxt_st.desat  = ~st_ff.cfg.mode[PFS_RFB_BIT];
      nxt_st.current_sense_output  = st_ff.cfg.mode[PFS_RFB_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_ff             <= '0;
      st_ff.cfg.mode    <= PFS_MODE_RST;
      st_ff.cfg.dbg     <= PFS_DBG_RST;
      // safe reset: master clear assumed on, pull-up on, ioc off
      st_ff.cfg.master_clear_input_en <= 1'b1;
      st_ff.a5_pu       <= 1'b1;
      st_ff.fb_res      <= 1'b1;
      st_ff.desat       <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign port_a_pin0_o              = st_ff.a0.o;
  assign port_a_pin0_oe             = st_ff.a0.oe;
  assign port_a_pin0_pu             = st_ff.a0.pu;
  assign port_a_pin1_o              = st_ff.a1.o;
  assign port_a_pin1_oe             = st_ff.a1.oe;
  assign port_a_pin1_pu             = st_ff.a1.pu;
  assign port_b_pin1_o              = st_ff.b1.o;
  assign port_b_pin1_oe             = st_ff.b1.oe;
  assign port_b_pin1_pu             = st_ff.b1.pu;
  assign port_b_pin1_ana_sel        = st_ff.b1_ana;
  assign port_a_pin5_pu             = st_ff.a5_pu;
  assign pin_change_interrupt_en_a5 = st_ff.a5_ioc;
  assign feedback_resistor_en       = st_ff.fb_res;
  assign desat_positive_input_en    = st_ff.desat;
  assign current_sense_output_en    = st_ff.current_sense_output;
  // sync input only meaningful in slave mode
  assign sync_in = sync_in_q & (msc_of(st_ff.cfg.mode) == PFS_MSC_SLAVE);
endmodule : pfs_top

// File: sim/pfs_top_asserts.sv
// assertion checker for pin function selection
`timescale 1ns/10ps
module pfs_top_asserts
  import pfs_pkg::*;
(
  // clocking
  input wire logic                  mclk,
  input wire logic                  reset_n,
  input wire logic                  clk_en,
  // configuration
  input wire logic                  master_clear_en,
  input wire logic                  sw_pullup_a5,
  input wire logic [PFS_MODE_W-1:0] mode_control_reg,
  input wire logic [PFS_DBG_W-1:0]  debug_output_control,
  // sources and gpio
  input wire logic                  debug_out_src,
  input wire logic                  sync_out_src,
  input wire logic                  gpio_a0_o,
  input wire logic                  gpio_a1_o,
  input wire logic                  gpio_a1_oe,
  // outputs
  input wire logic                  port_a_pin0_o,
  input wire logic                  port_a_pin1_o,
  input wire logic                  port_a_pin1_oe,
  input wire logic                  port_b_pin1_oe,
  input wire logic                  port_b_pin1_ana_sel,
  input wire logic                  port_a_pin5_pu,
  input wire logic                  pin_change_interrupt_en_a5,
  input wire logic                  feedback_resistor_en,
  input wire logic                  current_sense_output_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // config inputs show two edges later, sources one edge later
  logic v_ff;
  logic v2_ff;
  always_ff @(posedge mclk) begin
    v_ff  <= reset_n & clk_en;
    v2_ff <= v_ff;
  end
  wire live = clk_en & v_ff & v2_ff;
  chk_ioc_off_master_clear_input: assert property (
    live && $past(master_clear_en, 2) |-> !pin_change_interrupt_en_a5) else $error("ioc left on");
  chk_a5_pullup: assert property (live |->
    port_a_pin5_pu == ($past(master_clear_en, 2) | $past(sw_pullup_a5, 2)))
    else $error("a5 pull-up");
  chk_vref_master: assert property (live |->
    port_b_pin1_ana_sel == ($past(mode_control_reg[1:0], 2) == PFS_MSC_MASTER))
    else $error("vref");
  chk_vref_nodrive: assert property (
    port_b_pin1_ana_sel |-> !port_b_pin1_oe) else $error("b1 driven under vref");
  chk_sync_master: assert property (
    live && $past(mode_control_reg[1:0], 2) == PFS_MSC_MASTER
    |-> port_a_pin1_oe && port_a_pin1_o == $past(sync_out_src)) else $error("sync out");
  chk_rfb_select: assert property (live |->
    feedback_resistor_en != $past(mode_control_reg[PFS_RFB_BIT], 2) &&
    current_sense_output_en == $past(mode_control_reg[PFS_RFB_BIT], 2)) else $error("rfb");
  chk_debug_route: assert property (live |-> port_a_pin0_o ==
    ($past(debug_output_control[0], 2) ? $past(debug_out_src) : $past(gpio_a0_o)))
    else $error("dbg");
  chk_gpio_plain: assert property (live && !$past(mode_control_reg[0], 2) ==
    !$past(mode_control_reg[1], 2) |-> port_a_pin1_o == $past(gpio_a1_o) &&
    port_a_pin1_oe == $past(gpio_a1_oe)) else $error("a1 not plain gpio");
  cover property (live && port_b_pin1_ana_sel);
  cover property (live && current_sense_output_en);
  cover property (live && port_a_pin5_pu && !master_clear_en);
endmodule : pfs_top_asserts

bind pfs_top pfs_top_asserts i_pfs_top_asserts (.*);

// File: sim/pfs_top_tb.sv
// self-checking bench for pin function selection
`timescale 1ns/10ps
module pfs_top_tb;
  import pfs_pkg::*;
  logic mclk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, master_clear_en = 1'h1, sw_pullup_a5 = 1'h0;
  logic sw_ioc_en_a5 = 1'h0, debug_out_src = 1'h0, sync_out_src = 1'h0, port_a_pin1_i = 1'h0;
  logic secondary_reference_out = 1'h0, gpio_a0_o = 1'h0, gpio_a0_oe = 1'h1, gpio_a0_pu = 1'h0;
  logic gpio_a1_o = 1'h1, gpio_a1_oe = 1'h1, gpio_a1_pu = 1'h0;
  logic gpio_b1_o = 1'h1, gpio_b1_oe = 1'h1, gpio_b1_pu = 1'h0;
  logic [7:0] mode_control_reg = 8'h00, debug_output_control = 8'h00;
  logic port_a_pin0_o, port_a_pin0_oe, port_a_pin0_pu, port_a_pin1_o, port_a_pin1_oe;
  logic port_a_pin1_pu, port_b_pin1_o, port_b_pin1_oe, port_b_pin1_pu, port_b_pin1_ana_sel;
  logic port_a_pin5_pu, pin_change_interrupt_en_a5, sync_in;
  logic feedback_resistor_en, desat_positive_input_en, current_sense_output_en;
  int   fail_count = 0;
  int   checked = 0;
  pfs_top i_pfs_top (.*);
  always #2 mclk = ~mclk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // config takes two edges to reach the pins
  task automatic settle;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  task automatic t_master_clear_input;
    for (int k = 0; k < 8; k++) begin
      {master_clear_en, sw_pullup_a5, sw_ioc_en_a5} = 3'(k);
      settle();
      check(8'(port_a_pin5_pu), 8'(k[2] | k[1]));
      check(8'(pin_change_interrupt_en_a5), 8'(k[0] & !k[2]));
    end
    $display("master clear test done");
  endtask : t_master_clear_input
  task automatic t_msc;
    port_a_pin1_i = 1'h1;
    sync_out_src  = 1'h1;
    for (int m = 0; m < 4; m++) begin
      mode_control_reg = 8'(m);
      settle();
      check(8'(port_b_pin1_ana_sel), 8'(m == 1));
      check(8'(port_b_pin1_oe), 8'(m != 1));
      check(8'(port_a_pin1_oe), 8'(m != 2));
      check(8'(port_a_pin1_o), 8'(m != 2));
      check(8'(port_b_pin1_o), 8'(m != 1));
      check(8'(sync_in), 8'(m == 2));
    end
    $display("master slave test done");
  endtask : t_msc
  task automatic t_rfb;
    for (int b = 0; b < 2; b++) begin
      mode_control_reg = b ? 8'h40 : 8'h00;
      settle();
      check(8'({feedback_resistor_en, desat_positive_input_en, current_sense_output_en}),
            b ? 8'h01 : 8'h06);
    end
    $display("feedback select test done");
  endtask : t_rfb
  task automatic t_dbg;
    debug_out_src = 1'h1;
    for (int d = 0; d < 2; d++) begin
      debug_output_control = 8'(d);
      settle();
      check(8'(port_a_pin0_o), 8'(d));
    end
    $display("debug route test done");
  endtask : t_dbg
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'h1;
    check(8'({port_a_pin5_pu, pin_change_interrupt_en_a5}), 8'h02);
    t_master_clear_input();
    t_msc();
    t_rfb();
    t_dbg();
    give_verdict();
  end
endmodule : pfs_top_tb
